// File: rtl/port_pin_mode_config.sv
// Port pin output mode, input mode, pull-up and crossbar control
// Notes on behaviour
// R1: A pin's output mode bit sets its driver type even on crossbar pins.
// R2: Data, clock and mode-0 receive pins always drive open-drain.
// R3: Software makes a digital input with open-drain mode and data bit one.
// R4: A pin given to a peripheral input function has its driver disabled.
// R5: After reset every pin has its weak pull-up enabled; pullupEn resets to zero and turns on at the first clock after reset ends.
// R6: The global pull-up disable bit turns off every weak pull-up.
// R7: A pin driving low never has its weak pull-up on.
// R8: A port 1 input mode bit of zero is analog, one is digital.
// R9: After reset every input mode bit selects digital input.
// R10: An analog pin reads zero in the port data register.
// R11: An analog pin has its weak pull-up off regardless of the global bit.
// R12: The crossbar skips analog pins and moves on to the next pin.
// R13: Software should make analog pins open-drain with data one.
// R14: Software may sample a port 1 pin without analog mode, not advised.
// R15: Output mode one is push-pull, zero is open-drain.
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`default_nettype none
module port_pin_mode_config
  import gpio_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire axi_req_t axiIn,
  output axi_rsp_t axiOut,
  input wire logic [PINS-1:0] pinIn,
  output logic [PINS-1:0] pinOut,
  output logic [PINS-1:0] pinOe,
  output logic [PINS-1:0] pullupEn,
  output logic [PORT_W-1:0] analogSel,
  input wire logic [SIG_N-1:0] periphOut,
  output logic [SIG_N-1:0] periphIn
);
  typedef struct packed {
    axi_rsp_t rsp;
    logic awHave;
    logic [AXI_AW-1:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic [31:0] data;
    logic [31:0] omode;
    logic [7:0] imode;
    logic [5:0] xbr1;
    logic [7:0] crossbar_config_2;
    logic [1:0] smode;
    logic [PINS-1:0] sync1;
    logic [PINS-1:0] sync2;
    logic [PINS-1:0] pinOut;
    logic [PINS-1:0] pinOe;
    logic [PINS-1:0] pullupEn;
    logic [PORT_W-1:0] analogSel;
    logic [SIG_N-1:0] periphIn;
  } state_t;

  state_t q;
  state_t d;
  logic [PINS-1:0] analog;
  logic [PINS-1:0] xValid;
  logic [PINS-1:0][SIG_W-1:0] xSig;
  logic [PINS-1:0] forcedOd;
  logic [PINS-1:0] inOnly;
  logic [PINS-1:0] pushPull;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic regHit(logic [AXI_AW-1:0] a);
    logic [AXI_AW-1:0] w;
    w = {a[AXI_AW-1:2], 2'b00};
    regHit = (w == OFS_DATA) || (w == OFS_OMODE) || (w == OFS_IMODE) ||
             (w == OFS_XBR1) || (w == OFS_CROSSBAR_CONFIG_2) || (w == OFS_SMODE);
  endfunction : regHit

  function automatic logic [31:0] regWord(state_t s, logic [AXI_AW-1:0] a);
    logic [AXI_AW-1:0] w;
    w = {a[AXI_AW-1:2], 2'b00};
    regWord = '0;
    case (w)
      OFS_DATA: regWord = s.data;
      OFS_OMODE: regWord = s.omode;
      OFS_IMODE: regWord = {24'h00_0000, s.imode};
      OFS_XBR1: regWord = {26'h000_0000, s.xbr1};
      OFS_CROSSBAR_CONFIG_2: regWord = {24'h00_0000, s.crossbar_config_2};
      OFS_SMODE: regWord = {30'h0000_0000, s.smode};
      default: regWord = '0;
    endcase
  endfunction : regWord

  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n,
                                        logic [3:0] st);
    merge = o;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        merge[b*8 +: 8] = n[b*8 +: 8];
      end
    end
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    analog = '0;
    analog[PORT1_LSB +: PORT_W] = ~q.imode; // [R8]
  end

  pin_crossbar #(
    .NPINS(PINS),
    .NSIG(SIG_N)
  ) xbar (
    .enable(q.xbr1),
    .skip(analog),
    .pinValid(xValid),
    .pinSig(xSig)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [31:0] wv;
    logic [31:0] pinRead;
    logic [AXI_AW-1:0] wa;
    logic v;
    logic oe;
    wv = '0;
    pinRead = '0;
    wa = '0;
    v = 1'b0;
    oe = 1'b0;
    d = q;
    forcedOd = '0;
    inOnly = '0;
    pushPull = '0;

    // Pins cross two flops before anything reads them
    d.sync1 = pinIn;
    d.sync2 = q.sync1;
    // Analog pins have no digital input path
    pinRead = q.sync2 & ~analog; // [R10]

    // Write channel: address and data taken in either order
    if (axiIn.awvalid && q.rsp.awready) begin
      d.awHave = 1'b1;
      d.awAddr = axiIn.awaddr;
    end
    if (axiIn.wvalid && q.rsp.wready) begin
      d.wHave = 1'b1;
      d.wData = axiIn.wdata;
      d.wStrb = axiIn.wstrb;
    end
    if (q.rsp.bvalid && axiIn.bready) begin
      d.rsp.bvalid = 1'b0;
    end
    if (q.awHave && q.wHave && !q.rsp.bvalid) begin
      wa = {q.awAddr[AXI_AW-1:2], 2'b00};
      wv = merge(regWord(q, wa), q.wData, q.wStrb);
      case (wa)
        OFS_DATA: d.data = wv;
        OFS_OMODE: d.omode = wv;
        OFS_IMODE: d.imode = wv[7:0]; // [R8]
        OFS_XBR1: d.xbr1 = wv[5:0];
        OFS_CROSSBAR_CONFIG_2: d.crossbar_config_2 = wv[7:0]; // [R6]
        OFS_SMODE: d.smode = wv[1:0];
        default: d.data = q.data;
      endcase
      d.awHave = 1'b0;
      d.wHave = 1'b0;
      d.rsp.bvalid = 1'b1;
      d.rsp.bresp = regHit(q.awAddr) ? RESP_OKAY : RESP_SLVERR;
    end
    d.rsp.awready = !d.awHave;
    d.rsp.wready = !d.wHave;

    // Read channel: one word answered the cycle after the address
    if (q.rsp.rvalid && axiIn.rready) begin
      d.rsp.rvalid = 1'b0;
    end
    if (axiIn.arvalid && q.rsp.arready) begin
      d.rsp.rvalid = 1'b1;
      d.rsp.rresp = regHit(axiIn.araddr) ? RESP_OKAY : RESP_SLVERR;
      if ({axiIn.araddr[AXI_AW-1:2], 2'b00} == OFS_DATA) begin
        d.rsp.rdata = pinRead; // [R10]
      end else begin
        d.rsp.rdata = regWord(q, axiIn.araddr);
      end
    end
    d.rsp.arready = !d.rsp.rvalid;

    // Pin drivers
    for (int p = 0; p < PINS; p++) begin
      v = q.data[p];
      if (xValid[p]) begin
        v = periphOut[xSig[p]];
        case (xSig[p])
          SIG_SDA, SIG_SCL: forcedOd[p] = 1'b1; // [R2]
          SIG_S0_RX: begin
            // Mode 0 receive line doubles as open-drain data
            forcedOd[p] = q.smode[SMODE_S0]; // [R2]
            inOnly[p] = !q.smode[SMODE_S0]; // [R4]
          end
          SIG_S1_RX: begin
            forcedOd[p] = q.smode[SMODE_S1]; // [R2]
            inOnly[p] = !q.smode[SMODE_S1]; // [R4]
          end
          default: forcedOd[p] = 1'b0;
        endcase
      end
      // Mode bit applies whether or not the crossbar owns the pin
      pushPull[p] = q.omode[p] && !forcedOd[p] && !inOnly[p]; // [R1] [R15]
      if (inOnly[p]) begin
        oe = 1'b0; // [R4]
      end else if (pushPull[p]) begin
        oe = 1'b1; // [R15]
      end else begin
        // Open-drain: a one leaves the pin floating
        oe = !v; // [R3] [R13] [R15]
      end
      d.pinOut[p] = v;
      d.pinOe[p] = oe;
      d.pullupEn[p] = !q.crossbar_config_2[PUD_BIT] && !analog[p] && !(oe && !v); // [R5] [R6] [R7] [R11]
    end
    d.analogSel = ~q.imode; // [R8] [R14]

    // Unassigned peripheral inputs idle high
    for (int s = 0; s < SIG_N; s++) begin
      d.periphIn[s] = 1'b1;
      for (int p = 0; p < PINS; p++) begin
        if (xValid[p] && xSig[p] == SIG_W'(s)) begin
          d.periphIn[s] = q.sync2[p];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.rsp.awready <= 1'b1;
      q.rsp.wready <= 1'b1;
      q.rsp.arready <= 1'b1;
      q.data <= RST_DATA;
      q.omode <= RST_OMODE;
      q.imode <= RST_IMODE; // [R9]
      q.xbr1 <= RST_XBR1;
      q.crossbar_config_2 <= RST_CROSSBAR_CONFIG_2; // [R5]
      q.smode <= RST_SMODE;
      q.periphIn <= '1;
    end else begin
      q <= d;
    end
  end

  assign axiOut = q.rsp;
  assign pinOut = q.pinOut;
  assign pinOe = q.pinOe;
  assign pullupEn = q.pullupEn;
  assign analogSel = q.analogSel;
  assign periphIn = q.periphIn;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_dataRead;
    axiIn.arvalid && axiOut.arready && axiIn.araddr == OFS_DATA;
  endsequence

  sequence s_imodeWrite;
    q.awHave && q.wHave && !axiOut.bvalid && q.awAddr == OFS_IMODE && q.wStrb[0];
  endsequence

  chk_global_pullup_off: assert property ( // [R6]
    q.crossbar_config_2[PUD_BIT] |=> pullupEn == '0)
    else $error("pull-up on while globally disabled");

  chk_idle_pullup_on: assert property ( // [R5]
    !q.crossbar_config_2[PUD_BIT] && &q.imode && q.omode == '0 && q.data == RST_DATA &&
    xValid == '0 |=> pullupEn == '1)
    else $error("pull-up off on idle pin");

  chk_low_no_pullup: assert property ( // [R7]
    (pullupEn & pinOe & ~pinOut) == '0)
    else $error("pull-up on while pin drives low");

  chk_analog_pullup_off: assert property ( // [R11]
    (pullupEn[PORT1_LSB +: PORT_W] & analogSel) == '0)
    else $error("pull-up on an analog pin");

  chk_analog_read_zero: assert property ( // [R10]
    s_dataRead |=> (axiOut.rdata[PORT1_LSB +: PORT_W] & ~$past(q.imode)) == '0)
    else $error("analog pin read nonzero");

  chk_input_mode_write: assert property ( // [R8]
    s_imodeWrite ##1 1'b1 |-> q.imode == $past(q.wData[7:0]) ##1 analogSel == ~$past(q.wData[7:0], 2))
    else $error("input mode write not applied");

  chk_push_pull_drive: assert property ( // [R1]
    pushPull != '0 |=> (pinOe & $past(pushPull)) == $past(pushPull))
    else $error("push-pull pin not driven");

  chk_forced_open_drain: assert property ( // [R2]
    forcedOd != '0 |=> (pinOe & pinOut & $past(forcedOd)) == '0)
    else $error("forced open-drain pin driven high");

  chk_input_no_drive: assert property ( // [R4]
    inOnly != '0 |=> (pinOe & $past(inOnly)) == '0)
    else $error("peripheral input pin driven");

  chk_skip_analog_pin: assert property ( // [R12]
    (xValid & analog) == '0)
    else $error("crossbar used an analog pin");
endmodule : port_pin_mode_config
`default_nettype wire

// File: rtl/gpio_pkg.sv
// Constants and carriers shared by the port pin configuration block
`default_nettype none
package gpio_pkg;
  localparam int PINS = 32;
  localparam int PORT_W = 8;
  localparam int PORT1_LSB = 8;
  localparam int AXI_AW = 8;
  localparam int SIG_N = 6;
  localparam int SIG_W = 3;

  // Crossbar signal order, which is also the allocation priority
  localparam logic [2:0] SIG_S0_TX = 3'h0;
  localparam logic [2:0] SIG_S0_RX = 3'h1;
  localparam logic [2:0] SIG_SDA = 3'h2;
  localparam logic [2:0] SIG_SCL = 3'h3;
  localparam logic [2:0] SIG_S1_TX = 3'h4;
  localparam logic [2:0] SIG_S1_RX = 3'h5;

  // Register byte offsets
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_OMODE = 8'h04;
  localparam logic [7:0] OFS_IMODE = 8'h08;
  localparam logic [7:0] OFS_XBR1 = 8'h0C;
  localparam logic [7:0] OFS_CROSSBAR_CONFIG_2 = 8'h10;
  localparam logic [7:0] OFS_SMODE = 8'h14;

  // Field positions
  localparam int PUD_BIT = 7;
  localparam int SMODE_S0 = 0;
  localparam int SMODE_S1 = 1;

  // Reset values
  localparam logic [31:0] RST_DATA = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_OMODE = 32'h0000_0000;
  localparam logic [7:0] RST_IMODE = 8'hFF;
  localparam logic [5:0] RST_XBR1 = 6'h00;
  localparam logic [7:0] RST_CROSSBAR_CONFIG_2 = 8'h00;
  localparam logic [1:0] RST_SMODE = 2'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [AXI_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AXI_AW-1:0] araddr;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;
endpackage : gpio_pkg
`default_nettype wire

// File: rtl/pin_crossbar.sv
// Priority crossbar handing enabled peripheral signals to free pins
`default_nettype none
module pin_crossbar
  import gpio_pkg::*;
#(
  parameter int NPINS = PINS,
  parameter int NSIG = SIG_N
) (
  input wire logic [NSIG-1:0] enable,
  input wire logic [NPINS-1:0] skip,
  output logic [NPINS-1:0] pinValid,
  output logic [NPINS-1:0][SIG_W-1:0] pinSig
);
  always_comb begin
    int cur;
    logic found;
    cur = 0;
    found = 1'b0;
    pinValid = '0;
    pinSig = '0;
    for (int p = 0; p < NPINS; p++) begin
      // Skipped pins pass the pending signal on to the next pin
      if (!skip[p]) begin // [R12]
        found = 1'b0;
        for (int s = 0; s < NSIG; s++) begin
          if (!found && s >= cur && enable[s]) begin
            found = 1'b1;
            pinValid[p] = 1'b1;
            pinSig[p] = SIG_W'(s);
            cur = s + 1;
          end
        end
      end
    end
  end
endmodule : pin_crossbar
`default_nettype wire

// File: test/pin_partner.sv
// Model of the circuitry hanging on the port pins
`default_nettype none
module pin_partner
  import gpio_pkg::*;
(
  input wire logic mclk,
  input wire logic [PINS-1:0] pinOut,
  input wire logic [PINS-1:0] pinOe,
  input wire logic [PINS-1:0] pullupEn,
  input wire logic [PINS-1:0] extEn,
  input wire logic [PINS-1:0] extVal,
  output logic [PINS-1:0] pinLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [PINS-1:0] floatQ = '0;
  ////////////////////////////////////////////////////////////////////////////
  // Floating pins toggle so a stale level never reads as a match
  always_ff @(posedge mclk) begin
    floatQ <= ~floatQ;
  end
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (pinOe[i]) begin
        pinLevel[i] = pinOut[i];
      end else if (extEn[i]) begin
        pinLevel[i] = extVal[i];
      end else if (pullupEn[i]) begin
        pinLevel[i] = 1'b1;
      end else begin
        pinLevel[i] = floatQ[i];
      end
    end
  end
endmodule : pin_partner
`default_nettype wire

// File: test/port_pin_mode_config_tb_top.sv
// Self-checking bench for the port pin configuration block
`default_nettype none
module port_pin_mode_config_tb_top
  import gpio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk;
  logic reset;
  axi_req_t axiIn;
  axi_rsp_t axiOut;
  logic [PINS-1:0] pinIn, pinOut, pinOe, pullupEn, extEn, extVal;
  logic [PORT_W-1:0] analogSel;
  logic [SIG_N-1:0] periphOut;
  logic [SIG_N-1:0] periphIn;
  logic [31:0] rd;
  logic [1:0] rsp;
  int errorCnt = 0;
  int comparisons = 0;

  port_pin_mode_config u_dut (.mclk(mclk), .reset(reset), .axiIn(axiIn), .axiOut(axiOut),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pullupEn(pullupEn),
    .analogSel(analogSel), .periphOut(periphOut), .periphIn(periphIn));
  pin_partner u_pins (.mclk(mclk), .pinOut(pinOut), .pinOe(pinOe), .pullupEn(pullupEn),
    .extEn(extEn), .extVal(extVal), .pinLevel(pinIn));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (errorCnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    axiIn.awvalid <= 1'b1;
    axiIn.awaddr <= a;
    axiIn.wvalid <= 1'b1;
    axiIn.wdata <= d;
    axiIn.wstrb <= 4'hF;
    axiIn.bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (axiIn.awvalid && axiOut.awready) axiIn.awvalid <= 1'b0;
      if (axiIn.wvalid && axiOut.wready) axiIn.wvalid <= 1'b0;
    end while (!axiOut.bvalid && n < 40);
    r = axiOut.bresp;
    axiIn.bready <= 1'b0;
    if (n >= 40) errorCnt++;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    axiIn.arvalid <= 1'b1;
    axiIn.araddr <= a;
    axiIn.rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (axiIn.arvalid && axiOut.arready) axiIn.arvalid <= 1'b0;
    end while (!axiOut.rvalid && n < 40);
    d = axiOut.rdata;
    r = axiOut.rresp;
    axiIn.rready <= 1'b0;
    if (n >= 40) errorCnt++;
  endtask : axi_rd

  // Waits let the pin outputs and the input synchronisers settle
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, rsp);
    chk("bresp", {30'h0, rsp}, {30'h0, RESP_OKAY});
    repeat (3) @(posedge mclk);
  endtask : wr_reg

  task automatic rd_reg(input string name, input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a, rd, rsp);
    chk(name, rd, exp);
  endtask : rd_reg

  task automatic drive(input logic [31:0] en, input logic [31:0] val);
    extEn <= en;
    extVal <= val;
    repeat (4) @(posedge mclk);
  endtask : drive

  task automatic pout(input logic [SIG_N-1:0] v);
    periphOut <= v;
    repeat (3) @(posedge mclk);
  endtask : pout
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    axiIn = '0;
    extEn = '0;
    extVal = '0;
    periphOut = '0;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("pullupEn", pullupEn, 32'hFFFF_FFFF);
    chk("pinOe", pinOe, 32'h0);
    chk("analogSel", {24'h0, analogSel}, 32'h0);
    rd_reg("imode", OFS_IMODE, 32'hFF);
    rd_reg("omode", OFS_OMODE, 32'h0);
    rd_reg("data", OFS_DATA, 32'hFFFF_FFFF);
    axi_rd(8'h18, rd, rsp);
    chk("rresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    chk("rdata", rd, 32'h0);
    axi_wr(8'h18, 32'h1, rsp);
    chk("bresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr_reg(OFS_OMODE, 32'h1);
    wr_reg(OFS_DATA, 32'hFFFF_FFFC);
    chk("oe", pinOe & 32'h3, 32'h3);
    chk("out", pinOut & 32'h3, 32'h0);
    chk("pullup", pullupEn & 32'h3, 32'h0);
    wr_reg(OFS_DATA, 32'hFFFF_FFFE); // Pin 1 as digital input
    drive(32'h2, 32'h0);
    chk("oe", pinOe & 32'h3, 32'h1);
    chk("pullup", pullupEn & 32'h3, 32'h2);
    rd_reg("data", OFS_DATA, 32'hFFFF_FFFC);
    wr_reg(OFS_CROSSBAR_CONFIG_2, 32'h80);
    chk("pullupEn", pullupEn, 32'h0);
    rd_reg("crossbar_config_2", OFS_CROSSBAR_CONFIG_2, 32'h80);
    wr_reg(OFS_CROSSBAR_CONFIG_2, 32'h0);
    chk("pullupEn", pullupEn, 32'hFFFF_FFFE);
    wr_reg(OFS_DATA, 32'hFFFF_FFFF); // Analog pins left high impedance
    wr_reg(OFS_IMODE, 32'hF0);
    drive(32'hFF00, 32'hFF00);
    chk("analogSel", {24'h0, analogSel}, 32'hF);
    chk("pullupEn", pullupEn, 32'hFFFF_F0FF);
    rd_reg("data", OFS_DATA, 32'hFFFF_F0FF);
    wr_reg(OFS_IMODE, 32'hFF);
    drive(32'h0, 32'h0);
    wr_reg(OFS_XBR1, 32'h3);
    chk("oe", pinOe & 32'h3, 32'h1);
    chk("out", pinOut & 32'h1, 32'h0);
    pout(6'h1);
    chk("out", pinOut & 32'h1, 32'h1);
    wr_reg(OFS_OMODE, 32'h3);
    drive(32'h2, 32'h0);
    chk("oe", pinOe & 32'h3, 32'h1);
    chk("periphIn", {26'h0, periphIn}, 32'h3D);
    drive(32'h0, 32'h0);
    wr_reg(OFS_SMODE, 32'h1);
    chk("oe", pinOe & 32'h3, 32'h3);
    chk("out", pinOut & 32'h3, 32'h1);
    pout(6'h3);
    chk("oe", pinOe & 32'h3, 32'h1);
    wr_reg(OFS_XBR1, 32'h4);
    pout(6'h4);
    chk("oe", pinOe & 32'h1, 32'h0);
    pout(6'h0);
    chk("oe", pinOe & 32'h1, 32'h1);
    wr_reg(OFS_OMODE, 32'h0);
    wr_reg(OFS_XBR1, 32'h1);
    pout(6'h1);
    chk("oe", pinOe & 32'h1, 32'h0);
    pout(6'h0);
    chk("oe", pinOe & 32'h1, 32'h1);
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    errorCnt++;
    complete_run();
  end
endmodule : port_pin_mode_config_tb_top
`default_nettype wire
